// ### inc/mxb_pkg.sv
/*
 * Shared constants and types for the external bus and program-store block.
 * Assumes one clock that stands for the oscillator: one clk period is one oscillator period.
 */
package mxb_pkg;

	// Machine cycle framing, counted in oscillator periods
	localparam int OSC_PER_MC = 12;
	localparam int SLOT_LEN = 6;
	localparam logic [3:0] PHASE_LAST = 4'hb;
	localparam logic [3:0] SLOT_A_LAST = 4'h5;

	// Reset pin must stay high this many machine cycles
	localparam int RST_MIN_MC = 2;
	localparam int RST_HOLD_CLKS = OSC_PER_MC * RST_MIN_MC;
	localparam logic [4:0] RST_HOLD_CNT = 5'(RST_HOLD_CLKS);

	// Pin timing inside a slot, as slot offsets
	localparam logic [2:0] ALE_END = 3'h1;
	localparam logic [2:0] ADDR_END = 3'h2;
	localparam logic [2:0] CODE_FETCH_STROBE_BEG = 3'h3;
	localparam logic [2:0] CODE_FETCH_STROBE_END = 3'h5;

	// Data cycle strobe and write data window, as machine cycle phases
	localparam logic [3:0] XSTB_BEG = 4'h3;
	localparam logic [3:0] XSTB_END = 4'h8;
	localparam logic [3:0] XDAT_END = 4'h9;

	// Pin inputs lag the pins by the synchroniser depth, so sampling is moved late by it
	localparam int SYNC_LAG = 3;
	localparam logic [3:0] CAP_A_PH = 4'(5 + SYNC_LAG);
	localparam logic [3:0] CAP_B_PH = 4'(5 + SYNC_LAG - OSC_PER_MC + SLOT_LEN);
	localparam logic [3:0] XCAP_PH = 4'(8 + SYNC_LAG);

	// Verify data deadline, oscillator periods and clock cycles
	localparam int OSC_NS = 10;
	localparam int CLK_NS = 10;
	localparam int VERIFY_MAX_PER = 48;
	localparam int VERIFY_MAX_CLKS = (VERIFY_MAX_PER * OSC_NS) / CLK_NS;

	// Internal program store
	localparam int IMEM_DEPTH = 4096;
	localparam logic [15:0] IMEM_LAST = 16'h0fff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// Synchronised pin vector width
	localparam int PIN_W = 37;

	typedef enum logic [1:0] {
		MXB_RUN,
		MXB_PROGRAM_PULSE_IN,
		MXB_VERIFY,
		MXB_ERASE
	} mxb_mode_t;

	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mxb_xreq_t;

	typedef struct packed {
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] p2;
		logic [7:0] p3;
	} mxb_ports_t;

	typedef struct packed {
		logic serial_in;
		logic ext_irq_a;
		logic ext_irq_b;
		logic count_in_a;
		logic count_in_b;
	} mxb_alt_in_t;

endpackage

// ### hw/mxb_pin_sync.sv
/*
 * Three-stage synchroniser for a vector of pin inputs.
 * Assumes the pins are asynchronous to clk; a bit changes at the output once stages two and three agree.
 */
`timescale 1ns/100ps
module mxb_pin_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_sync
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] out_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Agreement filter only looks at stages two and three
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_ff <= '0;
		end else begin
			out_ff <= (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
		end
	end

	assign pin_sync = out_ff;

endmodule

// ### hw/mxb_bus_ctrl.sv
/*
 * External memory bus sequencer, port pin control and on-chip program store with programming and verify.
 * Assumes clk is the oscillator, a core that supplies fetch addresses, data requests and port latches,
 * and a pin wrapper that resolves each output/enable pair onto the package pin.
 */
// Behaviour
// - Reset pin high two machine cycles while clocked resets the core.
// - Address latch strobe pulses at one sixth of the oscillator rate.
// - Each external data access skips exactly one address latch pulse.
// - External code fetch asserts the fetch strobe twice per machine cycle.
// - External data access skips two fetch strobe pulses.
// - Fetch strobe stays inactive for internal program memory fetches.
// - Select pin high: internal memory up to 0fff, external above.
// - Select pin low: every fetch goes to external memory.
// - Port 0 carries low address first, then the data byte.
// - Address latch strobe lets outside logic capture the low address.
// - Port 2 drives the high address byte during external accesses.
// - Port 3 carries serial, interrupts, counters, and write/read strobes on 6,7.
// - Port 0 is open drain; ports 1 to 3 have pull-ups.
// - Erased store reads ones; programming only clears bits; erase sets them.
// - Programmer supplies write data on port 0; verify drives stored byte there.
// - Verify data is valid within 48 periods of a stable address.
`timescale 1ns/100ps
module mxb_bus_ctrl (
	input wire logic clk,
	input wire logic rst,
	// Package pins
	input wire logic reset_pin_in,
	input wire logic fetch_source_select,
	input wire logic program_pulse_in_enable_in,
	input wire logic vpp_present_in,
	input wire logic program_pulse_in,
	output logic ale_pin_o,
	output logic ale_pin_oe,
	output logic code_fetch_strobe_n,
	input wire logic [7:0] p0_in,
	output logic [7:0] p0_o,
	output logic [7:0] p0_oe,
	input wire logic [7:0] p1_in,
	output logic [7:0] p1_o,
	output logic [7:0] p1_oe,
	input wire logic [7:0] p2_in,
	output logic [7:0] p2_o,
	output logic [7:0] p2_oe,
	input wire logic [7:0] p3_in,
	output logic [7:0] p3_o,
	output logic [7:0] p3_oe,
	// Core side
	output logic core_rst,
	input wire logic [15:0] fetch_addr,
	output logic fetch_ready,
	output logic [7:0] code_byte,
	output logic code_valid,
	input wire logic xreq_valid,
	input wire mxb_pkg::mxb_xreq_t xreq,
	output logic xreq_ready,
	output logic [7:0] xrdata,
	output logic xdone,
	input wire mxb_pkg::mxb_ports_t port_latch,
	output mxb_pkg::mxb_ports_t port_pins,
	output mxb_pkg::mxb_alt_in_t alt_in,
	input wire logic erase_req
);

	logic [mxb_pkg::PIN_W-1:0] pins_s;
	logic rst_pin_s;
	logic ea_s;
	logic program_pulse_in_en_s;
	logic vpp_s;
	logic pulse_s;
	mxb_pkg::mxb_ports_t ports_s;

	mxb_pin_sync #(
		.W(mxb_pkg::PIN_W)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.pin_in({reset_pin_in, fetch_source_select, program_pulse_in_enable_in, vpp_present_in, program_pulse_in,
			p0_in, p1_in, p2_in, p3_in}),
		.pin_sync(pins_s)
	);

	assign {rst_pin_s, ea_s, program_pulse_in_en_s, vpp_s, pulse_s} = pins_s[36:32];
	assign ports_s = pins_s[31:0];

	// Fetch goes outside when the select pin is low or the address is past internal store
	function automatic logic is_ext_fetch(input logic ea, input logic [15:0] addr);
		is_ext_fetch = !ea || (addr > mxb_pkg::IMEM_LAST);
	endfunction

	logic [3:0] phase_ff;
	logic data_cycle_ff;
	logic slot_fetch_ff;
	logic slot_ext_ff;
	logic slot_bus_ff;
	logic [15:0] slot_addr_ff;
	mxb_pkg::mxb_xreq_t xreq_ff;
	mxb_pkg::mxb_mode_t mode_ff;
	logic [4:0] rst_cnt_ff;
	logic core_rst_ff;
	logic erase_busy_ff;
	logic [11:0] erase_addr_ff;
	logic pulse_d_ff;
	logic [7:0] verify_q_ff;
	logic [7:0] int_code_ff;
	logic [7:0] cap_code_ff;
	logic cap_fetch_ff;
	logic cap_ext_ff;
	logic [7:0] code_byte_ff;
	logic code_valid_ff;
	logic [7:0] xrdata_ff;
	logic xdone_ff;

	logic ale_ff;
	logic ale_oe_ff;
	logic code_fetch_strobe_n_ff;
	logic rd_n_ff;
	logic wr_n_ff;
	logic [7:0] p0_o_ff;
	logic [7:0] p0_oe_ff;
	logic [7:0] p1_oe_ff;
	logic [7:0] p2_o_ff;
	logic [7:0] p2_oe_ff;
	logic [7:0] p3_oe_ff;

	logic [7:0] imem [0:mxb_pkg::IMEM_DEPTH-1];

	logic run;
	logic slot_start;
	logic xtake;
	logic [3:0] nxt_phase;
	logic nxt_data_cycle;
	logic nxt_slot_fetch;
	logic nxt_slot_ext;
	logic nxt_slot_bus;
	logic [15:0] nxt_slot_addr;
	logic [2:0] nxt_sp;
	logic nxt_slot_a;
	logic nxt_ale;
	logic nxt_code_fetch_strobe_n;
	logic nxt_rd_n;
	logic nxt_wr_n;
	logic [7:0] nxt_p0_o;
	logic [7:0] nxt_p0_oe;
	logic [7:0] nxt_p2_o;
	logic [7:0] nxt_p2_oe;
	logic [11:0] program_pulse_in_addr;
	logic program_pulse_in_fall;

	assign run = (mode_ff == mxb_pkg::MXB_RUN);
	assign slot_start = (phase_ff == mxb_pkg::PHASE_LAST) || (phase_ff == mxb_pkg::SLOT_A_LAST);
	// One data cycle at a time, never two back to back
	assign xreq_ready = run && !core_rst_ff && !data_cycle_ff && (phase_ff == mxb_pkg::PHASE_LAST);
	assign xtake = xreq_valid && xreq_ready;
	assign fetch_ready = run && slot_start && !nxt_data_cycle;
	assign program_pulse_in_addr = {ports_s.p2[3:0], ports_s.p1};
	assign program_pulse_in_fall = pulse_d_ff && !pulse_s;

	// Next sequencer state, so that every pin is registered in step with the phase counter
	always_comb begin
		nxt_phase = (phase_ff == mxb_pkg::PHASE_LAST) ? 4'h0 : phase_ff + 4'h1;
		nxt_data_cycle = data_cycle_ff;
		if (!run) begin
			nxt_data_cycle = 1'b0;
		end else if (phase_ff == mxb_pkg::PHASE_LAST) begin
			nxt_data_cycle = xtake;
		end
		nxt_slot_fetch = slot_fetch_ff;
		nxt_slot_ext = slot_ext_ff;
		nxt_slot_bus = slot_bus_ff;
		nxt_slot_addr = slot_addr_ff;
		if (!run) begin
			nxt_slot_fetch = 1'b0;
			nxt_slot_ext = 1'b0;
			nxt_slot_bus = 1'b0;
		end else if (slot_start) begin
			if (nxt_data_cycle) begin
				nxt_slot_fetch = 1'b0;
				nxt_slot_ext = 1'b0;
				nxt_slot_bus = 1'b1;
				nxt_slot_addr = (phase_ff == mxb_pkg::PHASE_LAST) ? xreq.addr : xreq_ff.addr;
			end else begin
				nxt_slot_fetch = 1'b1;
				nxt_slot_ext = is_ext_fetch(ea_s, fetch_addr);
				nxt_slot_bus = nxt_slot_ext;
				nxt_slot_addr = fetch_addr;
			end
		end
		nxt_slot_a = (nxt_phase <= mxb_pkg::SLOT_A_LAST);
		nxt_sp = nxt_slot_a ? nxt_phase[2:0] : 3'(nxt_phase - 4'(mxb_pkg::SLOT_LEN));
	end

	// Pin decode for the coming phase
	always_comb begin
		nxt_ale = run && (nxt_sp <= mxb_pkg::ALE_END);
		if (nxt_data_cycle && !nxt_slot_a) begin
			nxt_ale = 1'b0;
		end
		nxt_code_fetch_strobe_n = !(run && nxt_slot_ext && (nxt_sp >= mxb_pkg::CODE_FETCH_STROBE_BEG) && (nxt_sp <= mxb_pkg::CODE_FETCH_STROBE_END));
		nxt_rd_n = 1'b1;
		nxt_wr_n = 1'b1;
		if (nxt_data_cycle && (nxt_phase >= mxb_pkg::XSTB_BEG) && (nxt_phase <= mxb_pkg::XSTB_END)) begin
			nxt_rd_n = xreq_ff.we;
			nxt_wr_n = !xreq_ff.we;
		end
		if (nxt_data_cycle && (phase_ff == mxb_pkg::PHASE_LAST)) begin
			nxt_rd_n = 1'b1;
			nxt_wr_n = 1'b1;
		end
		nxt_p0_o = 8'h00;
		nxt_p0_oe = ~port_latch.p0;
		if (mode_ff == mxb_pkg::MXB_VERIFY) begin
			nxt_p0_oe = ~verify_q_ff;
		end else if (!run) begin
			nxt_p0_oe = 8'h00;
		end else if (nxt_slot_bus && nxt_slot_a == 1'b1 && nxt_data_cycle && nxt_sp <= mxb_pkg::ADDR_END) begin
			nxt_p0_o = nxt_slot_addr[7:0];
			nxt_p0_oe = 8'hff;
		end else if (nxt_data_cycle && xreq_ff.we && (nxt_phase >= mxb_pkg::XSTB_BEG) &&
			(nxt_phase <= mxb_pkg::XDAT_END)) begin
			nxt_p0_o = xreq_ff.wdata;
			nxt_p0_oe = 8'hff;
		end else if (nxt_slot_ext && nxt_sp <= mxb_pkg::ADDR_END) begin
			nxt_p0_o = nxt_slot_addr[7:0];
			nxt_p0_oe = 8'hff;
		end else if (nxt_slot_bus) begin
			nxt_p0_oe = 8'h00;
		end
		nxt_p2_o = 8'h00;
		nxt_p2_oe = run ? ~port_latch.p2 : 8'h00;
		if (run && nxt_slot_bus) begin
			nxt_p2_o = nxt_slot_addr[15:8];
			nxt_p2_oe = 8'hff;
		end
	end

	// Mode from the straps, erase first; it moves only into the last phase so no pin pulse is cut short
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_ff <= mxb_pkg::MXB_RUN;
		end else if (nxt_phase == mxb_pkg::PHASE_LAST && erase_busy_ff) begin
			mode_ff <= mxb_pkg::MXB_ERASE;
		end else if (nxt_phase == mxb_pkg::PHASE_LAST && program_pulse_in_en_s) begin
			mode_ff <= vpp_s ? mxb_pkg::MXB_PROGRAM_PULSE_IN : mxb_pkg::MXB_VERIFY;
		end else if (nxt_phase == mxb_pkg::PHASE_LAST) begin
			mode_ff <= mxb_pkg::MXB_RUN;
		end
	end

	// Core reset needs the pin high for two whole machine cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_cnt_ff <= 5'h00;
			core_rst_ff <= 1'b1;
		end else if (!rst_pin_s) begin
			rst_cnt_ff <= 5'h00;
			core_rst_ff <= 1'b0;
		end else if (rst_cnt_ff == mxb_pkg::RST_HOLD_CNT - 5'h01) begin
			core_rst_ff <= 1'b1;
		end else begin
			rst_cnt_ff <= rst_cnt_ff + 5'h01;
		end
	end

	// Sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_ff <= mxb_pkg::PHASE_LAST;
			data_cycle_ff <= 1'b0;
			slot_fetch_ff <= 1'b0;
			slot_ext_ff <= 1'b0;
			slot_bus_ff <= 1'b0;
			slot_addr_ff <= 16'h0000;
			xreq_ff <= '0;
		end else begin
			phase_ff <= nxt_phase;
			data_cycle_ff <= nxt_data_cycle;
			slot_fetch_ff <= nxt_slot_fetch;
			slot_ext_ff <= nxt_slot_ext;
			slot_bus_ff <= nxt_slot_bus;
			slot_addr_ff <= nxt_slot_addr;
			if (xtake) begin
				xreq_ff <= xreq;
			end
		end
	end

	// Registered pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ale_ff <= 1'b0;
			ale_oe_ff <= 1'b0;
			code_fetch_strobe_n_ff <= 1'b1;
			rd_n_ff <= 1'b1;
			wr_n_ff <= 1'b1;
			p0_o_ff <= 8'h00;
			p0_oe_ff <= 8'h00;
			p1_oe_ff <= 8'h00;
			p2_o_ff <= 8'h00;
			p2_oe_ff <= 8'h00;
			p3_oe_ff <= 8'h00;
		end else begin
			ale_ff <= nxt_ale;
			// The latch strobe pin turns input for the program pulse
			ale_oe_ff <= run;
			code_fetch_strobe_n_ff <= nxt_code_fetch_strobe_n;
			rd_n_ff <= nxt_rd_n;
			wr_n_ff <= nxt_wr_n;
			p0_o_ff <= nxt_p0_o;
			p0_oe_ff <= nxt_p0_oe;
			p1_oe_ff <= run ? ~port_latch.p1 : 8'h00;
			p2_o_ff <= nxt_p2_o;
			p2_oe_ff <= nxt_p2_oe;
			// Strobe pins drive low through the quasi port only while active
			p3_oe_ff <= run ? ~(port_latch.p3 & {nxt_rd_n, nxt_wr_n, 6'h3f}) : 8'h00;
		end
	end

	// Erase sweep walks the whole store, one byte a cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			erase_busy_ff <= 1'b0;
			erase_addr_ff <= 12'h000;
		end else if (erase_busy_ff) begin
			erase_addr_ff <= erase_addr_ff + 12'h001;
			erase_busy_ff <= (erase_addr_ff != 12'hfff);
		end else if (erase_req) begin
			erase_busy_ff <= 1'b1;
			erase_addr_ff <= 12'h000;
		end
	end

	// Store has no reset; its content is what the erase sweep and programming left
	always_ff @(posedge clk) begin
		if (erase_busy_ff) begin
			imem[erase_addr_ff] <= mxb_pkg::ERASED_BYTE;
		end else if (mode_ff == mxb_pkg::MXB_PROGRAM_PULSE_IN && program_pulse_in_fall) begin
			imem[program_pulse_in_addr] <= imem[program_pulse_in_addr] & ports_s.p0;
		end
	end

	always_ff @(posedge clk) begin
		verify_q_ff <= imem[program_pulse_in_addr];
		int_code_ff <= imem[slot_addr_ff[11:0]];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pulse_d_ff <= 1'b0;
		end else begin
			pulse_d_ff <= pulse_s;
		end
	end

	// Snapshot each slot at its end, capture the pin byte once the synchroniser has caught up
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cap_fetch_ff <= 1'b0;
			cap_ext_ff <= 1'b0;
			cap_code_ff <= 8'h00;
		end else if (slot_start) begin
			cap_fetch_ff <= slot_fetch_ff && run;
			cap_ext_ff <= slot_ext_ff;
			cap_code_ff <= int_code_ff;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			code_byte_ff <= 8'h00;
			code_valid_ff <= 1'b0;
		end else begin
			code_valid_ff <= 1'b0;
			if (cap_fetch_ff && run && (phase_ff == mxb_pkg::CAP_A_PH || phase_ff == mxb_pkg::CAP_B_PH)) begin
				code_byte_ff <= cap_ext_ff ? ports_s.p0 : cap_code_ff;
				code_valid_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xrdata_ff <= 8'h00;
			xdone_ff <= 1'b0;
		end else begin
			xdone_ff <= 1'b0;
			if (data_cycle_ff && phase_ff == mxb_pkg::XCAP_PH) begin
				xrdata_ff <= xreq_ff.we ? xrdata_ff : ports_s.p0;
				xdone_ff <= 1'b1;
			end
		end
	end

	assign ale_pin_o = ale_ff;
	assign ale_pin_oe = ale_oe_ff;
	assign code_fetch_strobe_n = code_fetch_strobe_n_ff;
	assign p0_o = p0_o_ff;
	assign p0_oe = p0_oe_ff;
	assign p1_o = 8'h00;
	assign p1_oe = p1_oe_ff;
	assign p2_o = p2_o_ff;
	assign p2_oe = p2_oe_ff;
	assign p3_o = 8'h00;
	assign p3_oe = p3_oe_ff;
	assign core_rst = core_rst_ff;
	assign code_byte = code_byte_ff;
	assign code_valid = code_valid_ff;
	assign xrdata = xrdata_ff;
	assign xdone = xdone_ff;
	assign port_pins = ports_s;
	assign alt_in = {ports_s.p3[0], ports_s.p3[2], ports_s.p3[3], ports_s.p3[4], ports_s.p3[5]};

endmodule

// ### dv/mxb_bus_ctrl_props.sv
/*
 * Pin-level checks on the external bus sequencer, bound onto mxb_bus_ctrl.
 * Assumes one clock that stands for the oscillator and port latches held at all ones.
 */
`timescale 1ns/100ps
module mxb_bus_ctrl_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic reset_pin_in,
	input wire logic ale_pin_o,
	input wire logic ale_pin_oe,
	input wire logic code_fetch_strobe_n,
	input wire logic [7:0] p0_o,
	input wire logic [7:0] p0_oe,
	input wire logic [7:0] p1_o,
	input wire logic [7:0] p2_o,
	input wire logic [7:0] p2_oe,
	input wire logic [7:0] p3_o,
	input wire logic [7:0] p3_oe,
	input wire logic core_rst
);
	localparam int RST_HOLD = 24;
	logic [5:0] pin_hi_ff;
	logic xstb;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	assign xstb = p3_oe[7] | p3_oe[6];
	// Saturates so a long hold cannot wrap back below the minimum
	always_ff @(posedge clk or posedge rst) begin
		if (rst || !reset_pin_in)
			pin_hi_ff <= 6'h00;
		else if (pin_hi_ff != 6'h3f)
			pin_hi_ff <= pin_hi_ff + 6'h01;
	end
	chk_rst_hold_min: assert property ($rose(core_rst) |-> pin_hi_ff >= RST_HOLD)
		else $error("core reset rose too early");
	chk_ale_rate: assert property ($rose(ale_pin_o) |-> ##6 (ale_pin_o || xstb || !ale_pin_oe || core_rst))
		else $error("address strobe missed its slot");
	chk_ale_width: assert property ($rose(ale_pin_o) |=> ale_pin_o ##1 !ale_pin_o)
		else $error("address strobe width wrong");
	chk_ale_skip_one: assert property ($rose(xstb) |-> !ale_pin_o [*6] ##4 ale_pin_o)
		else $error("address strobe not skipped once");
	chk_xstb_len: assert property ($rose(xstb) |-> xstb [*6] ##1 !xstb)
		else $error("data strobe length wrong");
	chk_fetch_width: assert property ($fell(code_fetch_strobe_n) |-> !code_fetch_strobe_n [*3] ##1 code_fetch_strobe_n)
		else $error("fetch strobe width wrong");
	chk_fetch_skip: assert property ($rose(xstb) |-> code_fetch_strobe_n [*8])
		else $error("fetch strobe during data cycle");
	chk_fetch_mux: assert property ($fell(code_fetch_strobe_n) |->
		p0_oe == 8'h00 && $past(p0_oe) == 8'hff && $past(p2_oe, 3) == 8'hff)
		else $error("fetch address phase wrong");
	chk_data_bus: assert property (xstb |-> p0_oe == {8{p3_oe[6]}} && p2_oe == 8'hff)
		else $error("data cycle port drive wrong");
	chk_open_drain: assert property (p1_o == 8'h00 && p3_o == 8'h00 &&
		(p0_o & ~p0_oe) == 8'h00 && (p2_o & ~p2_oe) == 8'h00)
		else $error("port drives high without its enable");
endmodule
bind mxb_bus_ctrl mxb_bus_ctrl_props mxb_bus_ctrl_props_inst (.clk(clk), .rst(rst), .reset_pin_in(reset_pin_in),
	.ale_pin_o(ale_pin_o), .ale_pin_oe(ale_pin_oe), .code_fetch_strobe_n(code_fetch_strobe_n), .p0_o(p0_o),
	.p0_oe(p0_oe), .p1_o(p1_o), .p2_o(p2_o), .p2_oe(p2_oe), .p3_o(p3_o), .p3_oe(p3_oe), .core_rst(core_rst));

// ### dv/mxb_ext_mem.sv
/*
 * Behavioural external program and data memory on the multiplexed bus.
 * Assumes resolved pin levels as inputs and a pull-up on port 0 outside it.
 */
`timescale 1ns/100ps
module mxb_ext_mem (
	input wire logic ale,
	input wire logic fetch_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] ad,
	input wire logic [7:0] hi,
	output logic [7:0] dout,
	output logic dout_oe
);
	logic [15:0] addr_ff;
	logic [7:0] mem [0:65535];
	logic [65535:0] seen = '0;
	always @(negedge ale)
		addr_ff = {hi, ad};
	always @(posedge wr_n)
		if (!$isunknown(addr_ff)) begin
			mem[addr_ff] = ad;
			seen[addr_ff] = 1'b1;
		end
	// Released bus falls back to the pull-up, never to the last byte
	always @* begin
		dout_oe = !fetch_n || !rd_n;
		dout = seen[addr_ff] ? mem[addr_ff] : (addr_ff[7:0] ^ addr_ff[15:8] ^ 8'ha5);
	end
endmodule

// ### dv/mxb_bus_ctrl_tb_top.sv
/*
 * Self-checking bench: reset pin, fetch source, data cycles, programming and verify.
 * Assumes the package is compiled first and the checker binds itself.
 */
`timescale 1ns/100ps
module mxb_bus_ctrl_tb_top;
	// A real program pulse would exceed the run; the write happens at pulse start
	localparam int PULSE_CLKS = 200;
	localparam int LIMIT = 12000;
	logic clk = 1'b0, rst = 1'b1, reset_pin_in = 1'b0, fetch_source_select = 1'b0;
	logic program_pulse_in_enable_in = 1'b0, vpp_present_in = 1'b0, program_pulse_in = 1'b1, erase_req = 1'b0;
	logic xreq_valid = 1'b0, tb_p0_oe = 1'b0, mem_oe, ale_lvl;
	logic [15:0] fetch_addr = 16'h0000;
	mxb_pkg::mxb_xreq_t xreq = '0;
	mxb_pkg::mxb_ports_t port_latch = '1;
	mxb_pkg::mxb_ports_t port_pins;
	mxb_pkg::mxb_alt_in_t alt_in;
	logic [7:0] tb_p0 = 8'hff, tb_p1 = 8'hff, tb_p2 = 8'hff;
	logic ale_pin_o, ale_pin_oe, code_fetch_strobe_n, core_rst, code_valid, xreq_ready, xdone;
	logic [7:0] p0_o, p0_oe, p1_o, p1_oe, p2_o, p2_oe, p3_o, p3_oe, code_byte, xrdata, mem_d;
	logic [7:0] p0_lvl, p1_lvl, p2_lvl, p3_lvl;
	int fails = 0, num_checks = 0, cycles = 0, xdones = 0;
	always #5 clk = ~clk;
	always @(negedge clk)
		if (xdone === 1'b1)
			xdones++;
	assign p0_lvl = (p0_oe & p0_o) | (~p0_oe & (mem_oe ? mem_d : (tb_p0_oe ? tb_p0 : 8'hff)));
	assign p1_lvl = (p1_oe & p1_o) | (~p1_oe & tb_p1);
	assign p2_lvl = (p2_oe & p2_o) | (~p2_oe & tb_p2);
	assign p3_lvl = (p3_oe & p3_o) | ~p3_oe;
	assign ale_lvl = ale_pin_oe ? ale_pin_o : program_pulse_in;
	mxb_bus_ctrl mxb_bus_ctrl_inst (.clk(clk), .rst(rst), .reset_pin_in(reset_pin_in),
		.fetch_source_select(fetch_source_select), .program_pulse_in_enable_in(program_pulse_in_enable_in), .vpp_present_in(vpp_present_in),
		.program_pulse_in(program_pulse_in), .ale_pin_o(ale_pin_o), .ale_pin_oe(ale_pin_oe),
		.code_fetch_strobe_n(code_fetch_strobe_n), .p0_in(p0_lvl), .p0_o(p0_o), .p0_oe(p0_oe), .p1_in(p1_lvl),
		.p1_o(p1_o), .p1_oe(p1_oe), .p2_in(p2_lvl), .p2_o(p2_o), .p2_oe(p2_oe), .p3_in(p3_lvl), .p3_o(p3_o),
		.p3_oe(p3_oe), .core_rst(core_rst), .fetch_addr(fetch_addr), .fetch_ready(), .code_byte(code_byte),
		.code_valid(code_valid), .xreq_valid(xreq_valid), .xreq(xreq), .xreq_ready(xreq_ready), .xrdata(xrdata),
		.xdone(xdone), .port_latch(port_latch), .port_pins(port_pins), .alt_in(alt_in), .erase_req(erase_req));
	mxb_ext_mem mxb_ext_mem_inst (.ale(ale_lvl), .fetch_n(code_fetch_strobe_n), .rd_n(p3_lvl[7]),
		.wr_n(p3_lvl[6]), .ad(p0_lvl), .hi(p2_lvl), .dout(mem_d), .dout_oe(mem_oe));
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic clks(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Counts fetch strobe falls and address strobe rises over n settled samples
	task automatic watch(input int n, output logic [7:0] fetches, output logic [7:0] ales);
		logic f_q, a_q;
		fetches = 8'h00;
		ales = 8'h00;
		@(negedge clk);
		f_q = code_fetch_strobe_n;
		a_q = ale_pin_o;
		repeat (n) begin
			@(negedge clk);
			if (f_q && !code_fetch_strobe_n)
				fetches++;
			if (!a_q && ale_pin_o)
				ales++;
			f_q = code_fetch_strobe_n;
			a_q = ale_pin_o;
		end
	endtask
	task automatic t_reset_pin();
		int k;
		reset_pin_in <= 1'b1;
		clks(20);
		@(negedge clk);
		chk("core_rst early", 8'h00, {7'h00, core_rst});
		clks(12);
		@(negedge clk);
		chk("core_rst held", 8'h01, {7'h00, core_rst});
		@(posedge clk);
		reset_pin_in <= 1'b0;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (core_rst !== 1'b0 && k < 20);
		chk("core_rst released", 8'h00, {7'h00, core_rst});
	endtask
	task automatic t_fetch(input logic sel, input logic [15:0] a, input logic ext);
		logic [7:0] f, al;
		int k;
		@(posedge clk);
		fetch_source_select <= sel;
		fetch_addr <= a;
		clks(36);
		watch(24, f, al);
		chk("fetch strobes", ext ? 8'h04 : 8'h00, f);
		chk("address strobes", 8'h04, al);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (code_valid !== 1'b1 && k < 40);
		chk("code_byte", ext ? (a[7:0] ^ a[15:8] ^ 8'ha5) : 8'hff, code_byte);
		chk("alt inputs", 8'h1f, {3'h0, alt_in});
	endtask
	task automatic t_xfer(input logic we, input logic [15:0] a, input logic [7:0] d);
		logic [7:0] f, al;
		int k, x0;
		@(posedge clk);
		xreq <= {we, a, d};
		xreq_valid <= 1'b1;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (xreq_ready !== 1'b1 && k < 40);
		x0 = xdones;
		@(posedge clk);
		xreq_valid <= 1'b0;
		watch(36, f, al);
		chk("xdone pulses", 8'h01, 8'(xdones - x0));
		chk("address strobes data", 8'h05, al);
		chk("fetch strobes data", 8'h04, f);
		if (!we)
			chk("xrdata", d, xrdata);
	endtask
	task automatic t_program_pulse_in(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		program_pulse_in_enable_in <= 1'b1;
		vpp_present_in <= 1'b1;
		tb_p1 <= a[7:0];
		tb_p2 <= {4'h0, a[11:8]};
		tb_p0 <= d;
		tb_p0_oe <= 1'b1;
		clks(60);
		program_pulse_in <= 1'b0;
		clks(PULSE_CLKS);
		program_pulse_in <= 1'b1;
		clks(60);
		@(negedge clk);
		chk("p0 drive in program_pulse_in", 8'h00, p0_oe);
		chk("ale drive in program_pulse_in", 8'h00, {7'h00, ale_pin_oe});
		@(posedge clk);
	endtask
	task automatic t_verify(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk);
		vpp_present_in <= 1'b0;
		tb_p0_oe <= 1'b0;
		tb_p1 <= a[7:0];
		tb_p2 <= {4'h0, a[11:8]};
		clks(mxb_pkg::VERIFY_MAX_CLKS - 1);
		@(negedge clk);
		chk("verify byte", exp, p0_lvl);
		chk("port 1 pins", a[7:0], port_pins.p1);
	endtask
	initial begin
		clks(10);
		rst <= 1'b0;
		clks(40);
		erase_req <= 1'b1;
		clks(1);
		erase_req <= 1'b0;
		clks(4110);
		t_reset_pin();
		t_fetch(1'b1, 16'h0fff, 1'b0);
		t_fetch(1'b1, 16'h1000, 1'b1);
		t_fetch(1'b0, 16'h0123, 1'b1);
		t_xfer(1'b1, 16'h2345, 8'h3c);
		t_xfer(1'b0, 16'h2345, 8'h3c);
		t_program_pulse_in(12'h5a3, 8'hf0);
		t_program_pulse_in(12'h5a3, 8'h3c);
		t_verify(12'h5a3, 8'h30);
		t_verify(12'h5a4, 8'hff);
		give_verdict();
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles >= LIMIT) begin
			fails++;
			give_verdict();
		end
	end
endmodule
